// [design/sadc_pkg.sv]
// Functional notes
// - a falling read/convert line while the chip is enabled and low power is not requested starts a conversion
// - while converting, status is high and all twelve data outputs float
// - the result drives the outputs first; status falls about 1.5 clocks later
// - one conversion takes 38 cycles of the conversion clock
// - conversion clock is nominally 4 MHz, about 100k conversions per second
// - the 12-bit result comes from successive approximation on a DAC
// - chip enable, chip select and read/convert are equivalent start triggers
// - re-asserting the start condition abandons and restarts a conversion
// - enabled with byte select low, the full 12-bit result is driven
// - byte select high puts the 4 low bits and 4 zeros on the top byte
// - chip enable low or chip select high floats outputs and does nothing
// - serial output is MSB first, one bit per shift clock falling edge
// - shift clock activity is ignored while serial output is not enabled
package sadc_pkg;
  // result and byte layout
  localparam int RES_W  = 12;
  localparam int NIB_W  = 4;
  localparam int BYTE_W = 8;
  // clock rates and conversion schedule
  localparam int REF_CLK_KHZ   = 10000;
  localparam int CONV_CLK_KHZ  = 4000;
  localparam int CONV_TICKS    = 38;
  localparam int SAMPLE_TICKS  = 13;
  // status delay after data turn-on: 1.5 periods of the conversion clock
  localparam int REF_PERIOD_NS = 100;
  localparam int STS_DELAY_NS  = 375;
  localparam int STS_DELAY_CYC =
    (STS_DELAY_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  // result buffer
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    SADC_IDLE    = 2'b00,
    SADC_CONVERT = 2'b01,
    SADC_PUSH    = 2'b10,
    SADC_SETTLE  = 2'b11
  } sadc_state_t;

  typedef struct packed {
    logic ce;
    logic chip_select_low;
    logic read_not_convert;
    logic byte_select;
    logic low_power_request;
  } sadc_ctl_t;
endpackage

// [design/sadc_ctrl.sv]
module sadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // extra pointer bit separates full from empty
  assign in_ready  = !(wr_ptr[AW] != rd_ptr[AW] &&
                       wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers; flush drops words of an abandoned conversion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

module sadc_ctrl #(
  parameter int RES_W = sadc_pkg::RES_W
) (
  // system clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // serial shift clock from the host
  input  wire logic                sclk,
  // control pins
  input  wire sadc_pkg::sadc_ctl_t ctl_pins,
  // analog comparator and DAC
  input  wire logic                cmp_above,
  output logic [RES_W-1:0]         dac_code,
  output logic                     analog_sleep,
  // status and parallel data
  output logic                     conversion_status,
  output logic [RES_W-1:0]         data_out,
  output logic                     data_oe,
  // serial data
  output logic                     serial_result_out,
  output logic                     serial_oe
);
  localparam int          HI    = RES_W - 1;
  localparam int          STS_C = sadc_pkg::STS_DELAY_CYC;
  localparam logic [13:0] ACC_K = 14'(sadc_pkg::CONV_CLK_KHZ);
  localparam logic [13:0] ACC_M = 14'(sadc_pkg::REF_CLK_KHZ);
  localparam logic [5:0]  T_SMP = 6'(sadc_pkg::SAMPLE_TICKS);
  localparam logic [5:0]  T_END = 6'(sadc_pkg::CONV_TICKS - 1);
  localparam logic [2:0]  S_END = 3'(STS_C - 1);
  localparam logic [3:0]  P_TOP = 4'(HI);
  localparam logic [3:0]  N_BITS = 4'(RES_W);
  localparam int          NIB_HI = sadc_pkg::NIB_W - 1;

  logic [5:0]            pin_s1;
  logic [5:0]            pin_s2;
  sadc_pkg::sadc_ctl_t   ctl;
  logic                  cmp;
  logic                  enabled;
  logic                  start_cond;
  logic                  start_prev;
  logic                  start_evt;
  logic [13:0]           acc;
  logic                  conv_tick;
  sadc_pkg::sadc_state_t state;
  logic [5:0]            tick_count;
  logic [2:0]            settle_cnt;
  logic [3:0]            bit_ptr;
  logic [RES_W-1:0]      next_sar;
  logic                  sar_first;
  logic                  sar_decide;
  logic                  conv_done;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [RES_W-1:0]      fifo_out_data;
  logic                  drain_ready;
  logic [RES_W-1:0]      result_word;
  logic                  result_valid;
  logic                  next_oe;
  logic                  ser_clear;
  logic [3:0]            shift_cnt;

  // two-flop synchronisers on the control pins and the comparator input; sclk and resetn are not synchronised
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      pin_s1 <= {cmp_above, ctl_pins};
      pin_s2 <= pin_s1;
    end
  end
  assign ctl          = pin_s2[4:0];
  assign cmp          = pin_s2[5];
  assign analog_sleep = ctl.low_power_request;

  // any of the three lines can complete the start condition
  assign enabled    = ctl.ce && !ctl.chip_select_low;
  assign start_cond = enabled && !ctl.read_not_convert &&
                      !ctl.low_power_request;
  assign start_evt  = start_cond && !start_prev;

  // preset high, but the synchronisers reset low, so a start level held through reset still starts a conversion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) start_prev <= 1'b1;
    else start_prev <= start_cond;
  end

  // fractional divider: 4 ticks per 10 reference cycles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc       <= 14'h0000;
      conv_tick <= 1'b0;
    end else if (acc + ACC_K >= ACC_M) begin
      acc       <= acc + ACC_K - ACC_M;
      conv_tick <= 1'b1;
    end else begin
      acc       <= acc + ACC_K;
      conv_tick <= 1'b0;
    end
  end

  assign sar_first  = state == sadc_pkg::SADC_CONVERT && conv_tick &&
                      tick_count == T_SMP;
  assign sar_decide = state == sadc_pkg::SADC_CONVERT && conv_tick &&
                      tick_count > T_SMP && tick_count[0];
  assign conv_done  = state == sadc_pkg::SADC_CONVERT && conv_tick &&
                      tick_count == T_END;

  // sequencer; a new start wins in every state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= sadc_pkg::SADC_IDLE;
      tick_count <= 6'h00;
      settle_cnt <= 3'h0;
    end else if (start_evt) begin
      state      <= sadc_pkg::SADC_CONVERT;
      tick_count <= 6'h00;
      settle_cnt <= 3'h0;
    end else begin
      case (state)
        sadc_pkg::SADC_IDLE: begin
          state <= sadc_pkg::SADC_IDLE;
        end
        sadc_pkg::SADC_CONVERT: begin
          if (conv_tick) tick_count <= tick_count + 6'h01;
          if (conv_done) state <= sadc_pkg::SADC_PUSH;
        end
        sadc_pkg::SADC_PUSH: begin
          if (fifo_in_ready) state <= sadc_pkg::SADC_SETTLE;
        end
        sadc_pkg::SADC_SETTLE: begin
          // data drives first, status drops after the delay
          if (result_valid) settle_cnt <= settle_cnt + 3'h1;
          if (result_valid && settle_cnt == S_END) begin
            state <= sadc_pkg::SADC_IDLE;
          end
        end
        default: state <= sadc_pkg::SADC_IDLE;
      endcase
    end
  end
  assign conversion_status = (state != sadc_pkg::SADC_IDLE);

  // trial code: clear the bit under test if the DAC overshoots
  always_comb begin
    next_sar = dac_code;
    if (!cmp) next_sar[bit_ptr] = 1'b0;
    if (bit_ptr != 4'h0) next_sar[bit_ptr - 4'h1] = 1'b1;
  end

  // successive approximation register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dac_code <= '0;
      bit_ptr  <= P_TOP;
    end else if (start_evt) begin
      dac_code <= '0;
      bit_ptr  <= P_TOP;
    end else if (sar_first) begin
      dac_code[HI] <= 1'b1;
    end else if (sar_decide) begin
      dac_code <= next_sar;
      if (bit_ptr != 4'h0) bit_ptr <= bit_ptr - 4'h1;
    end
  end

  // drain stalls while the host is reading the current word
  assign drain_ready = !data_oe && !serial_oe;

  sadc_fifo #(
    .WIDTH (RES_W),
    .DEPTH (sadc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .flush     (start_evt),
    .in_valid  (state == sadc_pkg::SADC_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (dac_code),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  // held result, dropped only when a new conversion starts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_word  <= '0;
      result_valid <= 1'b0;
    end else if (start_evt) begin
      result_valid <= 1'b0;
    end else if (fifo_out_valid && drain_ready) begin
      result_word  <= fifo_out_data;
      result_valid <= 1'b1;
    end
  end

  // outputs only when enabled, reading, and not converting
  assign next_oe = enabled && ctl.read_not_convert && result_valid &&
                   (state == sadc_pkg::SADC_IDLE ||
                    state == sadc_pkg::SADC_SETTLE);

  // registered parallel and serial output enables and data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_oe   <= 1'b0;
      serial_oe <= 1'b0;
      ser_clear <= 1'b1;
      data_out  <= '0;
    end else begin
      data_oe   <= next_oe;
      serial_oe <= next_oe;
      ser_clear <= !next_oe;
      if (ctl.byte_select) begin
        data_out <= {result_word[NIB_HI:0], 4'h0, result_word[NIB_HI:0]};
      end else begin
        data_out <= result_word;
      end
    end
  end

  // shift count on the host clock; the async clear holds it at the MSB
  // while reads are disabled, so no stray edge can advance it
  always_ff @(negedge sclk or posedge ser_clear) begin
    if (ser_clear) shift_cnt <= 4'h0;
    else if (shift_cnt != N_BITS) shift_cnt <= shift_cnt + 4'h1;
  end
  assign serial_result_out = (shift_cnt == N_BITS) ? 1'b0 :
                             result_word[P_TOP - shift_cnt];

  // status drop seen over two samples
  sequence s_drop;
    conversion_status ##1 !conversion_status;
  endsequence

  property p_start;
    @(posedge ref_clk) disable iff (!resetn)
      start_evt |=> state == sadc_pkg::SADC_CONVERT && tick_count == 6'h00;
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_busy;
    @(posedge ref_clk) disable iff (!resetn)
      state == sadc_pkg::SADC_CONVERT |=> conversion_status && !data_oe;
  endproperty
  a_busy: assert property (p_busy) else $error("busy outputs");

  property p_sts_late;
    @(posedge ref_clk) disable iff (!resetn)
      s_drop |-> $past(result_valid && conversion_status, STS_C);
  endproperty
  a_sts_late: assert property (p_sts_late) else $error("status early");

  property p_length;
    @(posedge ref_clk) disable iff (!resetn)
      conv_done && !start_evt |=> state == sadc_pkg::SADC_PUSH &&
                                  $past(tick_count) == T_END;
  endproperty
  a_length: assert property (p_length) else $error("bad length");

  property p_tick;
    @(posedge ref_clk) disable iff (!resetn)
      conv_tick |=> !conv_tick ##[1:2] conv_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick rate");

  property p_restart;
    @(posedge ref_clk) disable iff (!resetn)
      state != sadc_pkg::SADC_IDLE && start_evt |=>
        conversion_status && !result_valid && tick_count == 6'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_word;
    @(posedge ref_clk) disable iff (!resetn)
      data_oe && !$past(ctl.byte_select) |-> data_out == $past(result_word);
  endproperty
  a_word: assert property (p_word) else $error("bad word");

  property p_byte;
    @(posedge ref_clk) disable iff (!resetn)
      data_oe && $past(ctl.byte_select) |->
        data_out[HI:4] == {$past(result_word[3:0]), 4'h0};
  endproperty
  a_byte: assert property (p_byte) else $error("bad byte");

  property p_off;
    @(posedge ref_clk) disable iff (!resetn)
      !enabled |=> !data_oe && !serial_oe && ser_clear;
  endproperty
  a_off: assert property (p_off) else $error("driven off");

  property p_shift;
    @(negedge sclk) disable iff (ser_clear)
      shift_cnt != N_BITS |=> shift_cnt == $past(shift_cnt) + 4'h1;
  endproperty
  a_shift: assert property (p_shift) else $error("shift step");

  property p_keep;
    @(posedge ref_clk) disable iff (!resetn)
      result_valid && !start_evt && !fifo_out_valid |=> $stable(result_word);
  endproperty
  a_keep: assert property (p_keep) else $error("result lost");
endmodule

// [dv/sadc_host_model.sv]
module sadc_host_model (
  // analog side
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] vin,
  output logic             cmp_above,
  // serial link
  input  wire logic        serial_result_out,
  output logic             sclk
);
  timeunit 1ns;
  timeprecision 100ps;

  // comparator: a trial code at or below the input keeps its bit
  assign cmp_above = (vin >= dac_code);

  // shift clock idles high and stands still between frames
  initial sclk = 1'b1;

  // one frame at 8 MHz, well under the load limit; bits sampled before fall
  task automatic shift(output logic [11:0] word);
    #37;
    for (int i = 11; i >= 0; i--) begin
      #62.5;
      word[i] = serial_result_out;
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
    end
  endtask
endmodule

// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LO = sadc_pkg::CONV_TICKS * sadc_pkg::REF_CLK_KHZ
                      / sadc_pkg::CONV_CLK_KHZ - 4;
  localparam int HI = LO + sadc_pkg::STS_DELAY_CYC + 20;

  logic                ref_clk;
  logic                resetn;
  logic                sclk;
  logic                cmp_above;
  logic                analog_sleep;
  logic                conversion_status;
  logic                data_oe;
  logic                serial_result_out;
  logic                serial_oe;
  logic [11:0]         dac_code;
  logic [11:0]         data_out;
  logic [11:0]         vin;
  logic [11:0]         word;
  sadc_pkg::sadc_ctl_t ctl;
  int                  error_cnt;
  int                  n_tests;

  sadc_ctrl sadc_ctrl_i (
    .ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .ctl_pins(ctl),
    .cmp_above(cmp_above), .dac_code(dac_code),
    .analog_sleep(analog_sleep), .conversion_status(conversion_status),
    .data_out(data_out), .data_oe(data_oe),
    .serial_result_out(serial_result_out), .serial_oe(serial_oe)
  );

  // a disabled serial line shows the inverse so a stale bit cannot pass
  sadc_host_model sadc_host_model_i (
    .dac_code(dac_code), .vin(vin), .cmp_above(cmp_above),
    .serial_result_out(serial_oe ? serial_result_out : !serial_result_out),
    .sclk(sclk)
  );

  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check_word(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // sample just after the edge so the design's updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // p is {ce, chip_select_low, read_not_convert}
  task automatic pins(input logic [2:0] p, input logic bs, input logic lp);
    @(posedge ref_clk);
    ctl <= '{p[2], p[1], p[0], bs, lp};
  endtask

  // follow one conversion from start to valid data
  task automatic await_done;
    int   cyc;
    logic prev_oe;
    cyc = 0;
    prev_oe = 1'b0;
    while (conversion_status !== 1'b1 && cyc < 8) begin
      step(1);
      cyc++;
    end
    check_bit(conversion_status, 1'b1);
    step(40);
    cyc += 40;
    check_bit(data_oe, 1'b0);
    while (conversion_status === 1'b1 && cyc < 200) begin
      prev_oe = data_oe;
      step(1);
      cyc++;
    end
    check_bit(prev_oe, 1'b1);
    check_bit(cyc >= LO && cyc <= HI, 1'b1);
  endtask

  // start from a given idle pattern, read the word and the second byte
  task automatic conv(input logic [11:0] v, input logic [2:0] pre);
    pins(pre, 1'b0, 1'b0);
    step(4);
    vin <= v;
    pins(3'b100, 1'b0, 1'b0);
    pins(3'b101, 1'b0, 1'b0);
    await_done();
    check_word(data_out, v);
    pins(3'b101, 1'b1, 1'b0);
    step(4);
    check_word(data_out, {v[3:0], 4'h0, v[3:0]});
    pins(3'b101, 1'b0, 1'b0);
    step(4);
  endtask

  task automatic t_triggers;
    logic [2:0]  pre [3] = '{3'b101, 3'b000, 3'b110};
    logic [11:0] val [3] = '{12'hfff, 12'h001, 12'ha5c};
    for (int k = 0; k < 3; k++) begin
      conv(val[k], pre[k]);
    end
  endtask

  task automatic t_disable;
    pins(3'b001, 1'b0, 1'b0);
    step(4);
    check_bit(data_oe, 1'b0);
    check_bit(conversion_status, 1'b0);
    pins(3'b101, 1'b0, 1'b0);
    step(4);
    check_word(data_out, 12'ha5c);
  endtask

  task automatic t_restart;
    vin <= 12'h123;
    pins(3'b100, 1'b0, 1'b0);
    pins(3'b101, 1'b0, 1'b0);
    step(40);
    check_bit(conversion_status, 1'b1);
    vin <= 12'h9e7;
    pins(3'b100, 1'b0, 1'b0);
    pins(3'b101, 1'b0, 1'b0);
    await_done();
    check_word(data_out, 12'h9e7);
  endtask

  task automatic t_serial;
    check_bit(serial_oe, 1'b1);
    sadc_host_model_i.shift(word);
    check_word(word, 12'h9e7);
    pins(3'b001, 1'b0, 1'b0);
    step(4);
    sadc_host_model_i.shift(word);
    check_word(word, 12'h000);
    pins(3'b101, 1'b0, 1'b0);
    step(4);
    sadc_host_model_i.shift(word);
    check_word(word, 12'h9e7);
  endtask

  // low power blocks starts; host waits out the wake delay afterwards
  task automatic t_sleep;
    pins(3'b101, 1'b0, 1'b1);
    step(4);
    check_bit(analog_sleep, 1'b1);
    pins(3'b100, 1'b0, 1'b1);
    step(8);
    check_bit(conversion_status, 1'b0);
    pins(3'b101, 1'b0, 1'b0);
    step(300);
    conv(12'h5a3, 3'b101);
  endtask

  // watchdog well beyond the expected run of about 1000 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    ctl = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    vin = 12'h000;
    error_cnt = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    step(2);
    check_bit(conversion_status, 1'b0);
    check_bit(data_oe, 1'b0);
    t_triggers();
    t_disable();
    t_restart();
    t_serial();
    t_sleep();
    stop_test();
  end
endmodule
